// ===== sim/pmlsr_host.sv
// Host model issuing single-byte register reads and writes
module pmlsr_host (
	input wire logic clk_in, // System clock
	output pmlsr_pkg::pmlsr_req_t req_out, // Register request
	input wire logic [7:0] rdata_in // Read data
);
	timeunit 1ns;
	timeprecision 1ps;

	initial req_out = '0;

	// Released address and data show inverted values so stale data is seen
	task automatic access(input logic [7:0] addr, input logic wr,
		input logic [7:0] wdata);
		@(posedge clk_in);
		#1;
		req_out = '{addr: addr, wr: wr, rd: !wr, wdata: wdata};
		@(posedge clk_in);
		#1;
		req_out = '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~wdata};
	endtask

	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		access(addr, 1'b0, 8'h00);
		@(posedge clk_in);
		#1;
		data = rdata_in;
	endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the misc register bank
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	pmlsr_pkg::pmlsr_req_t req;
	logic [11:0] codes = 12'h000;
	logic strap_hi = 1'b1;
	logic strap_lo = 1'b0;
	logic ov = 1'b0;
	logic byp = 1'b0;
	logic preq = 1'b0;
	logic creq = 1'b0;
	logic slow = 1'b0;
	logic sel = 1'b0;
	logic [7:0] rdata;
	logic [7:0] rd_val;
	pmlsr_pkg::pmlsr_led_t led_on;
	pmlsr_pkg::pmlsr_led_t led_blink;
	logic [14:0] led_ma;
	logic sw_on, pwm_blk, osc, csel, noramp, ck_lvl, ck_oe;
	logic [1:0] ilim;
	logic [11:0] lim_ma;
	logic blk_seen;
	logic [11:0] ma_tab [4] = '{12'h064, 12'h1F4, 12'h2EE, 12'h9C4};
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;

	always #2.5 clk_in = ~clk_in;
	always #15625 slow = ~slow;

	pmlsr_host i_pmlsr_host (.clk_in(clk_in), .req_out(req), .rdata_in(rdata));

	pmlsr_top i_pmlsr_top (.clk_in(clk_in), .rst_in(rst_in),
		.reg_req_in(req), .sink_current_code_in(codes),
		.switch_mode_strap_hi_in(strap_hi), .switch_mode_strap_lo_in(strap_lo),
		.conv_four_output_sense_in(ov), .bypass_cmp_in(byp),
		.power_request_in(preq), .clock_request_in(creq), .slow_clk_in(slow),
		.conv_select_in(sel), .reg_rdata_out(rdata), .led_on_out(led_on),
		.led_blink_out(led_blink), .led_ma_out(led_ma), .switch_on_out(sw_on),
		.forced_pwm_block_out(pwm_blk), .switch_current_limit_out(ilim),
		.switch_limit_ma_out(lim_ma), .fast_osc_run_out(osc),
		.conv_select_out(csel), .conv_voltage_no_ramp_out(noramp),
		.slow_clock_output_out(ck_lvl), .slow_clock_oe_out(ck_oe));

	// Latches a block pulse only while the overvoltage pin is raised
	always @(posedge clk_in) begin
		blk_seen <= ov && (blk_seen || pwm_blk === 1'b1);
	end

	task automatic complete_run();
		if (mismatches == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			complete_run();
		end
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic reg_chk(input string what, input logic [7:0] addr,
		input logic [7:0] exp);
		i_pmlsr_host.rd(addr, rd_val);
		chk(what, {8'h00, exp}, {8'h00, rd_val});
	endtask

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		i_pmlsr_host.access(addr, 1'b1, data);
	endtask

	initial begin
		wait_clk(2);
		rst_in = 1'b0;
		reg_chk("ls reset", 8'h62, 8'h08);
		reg_chk("led reset", 8'h61, 8'h00);
		reg_chk("spare reset", 8'h63, 8'h00);
		reg_chk("version", 8'h64, 8'hAA);
		wr(8'h64, 8'h55);
		reg_chk("version ro", 8'h64, 8'hAA);
		reg_chk("unmapped", 8'h70, 8'h00);
		wr(8'h61, 8'hFF);
		reg_chk("led rsvd", 8'h61, 8'h77);
		wr(8'h61, 8'h41);
		wait_clk(2);
		chk("led on", 16'(led_on), 16'h0004);
		chk("led blink", 16'(led_blink), 16'h0001);
		for (int c = 0; c < 16; c++) begin
			codes = {4'h3, 4'h9, 4'(c)};
			wait_clk(3);
			chk("sink ma", 16'(led_ma), {1'b0, 5'h08, 5'h14,
				(c > 9) ? 5'h14 : 5'(2 * c + 2)});
		end
		for (int i = 0; i < 4; i++) begin
			wr(8'h62, {6'h3F, 2'(i)});
			wait_clk(2);
			chk("limit ma", 16'(lim_ma), 16'(ma_tab[i]));
			chk("limit code", 16'(ilim), 16'(i));
		end
		reg_chk("ls rsvd", 8'h62, 8'h0F);
		for (int m = 0; m < 8; m++) begin
			byp = m[2];
			wr(8'h62, {4'h0, 2'(m), 2'h0});
			wait_clk(8);
			chk("switch", 16'(sw_on), 16'(m[0] | (m[1] & m[2])));
		end
		ov = 1'b1;
		wait_clk(10);
		chk("ov block", 16'(blk_seen), 16'h0001);
		chk("ov switch", 16'(sw_on), 16'h0000);
		reg_chk("ov clear", 8'h62, 8'h00);
		wr(8'h62, 8'h0B);
		reg_chk("ov wins", 8'h62, 8'h03);
		ov = 1'b0;
		for (int k = 0; k < 4; k++) begin
			{preq, creq} = 2'(k);
			wr(8'h63, 8'h08);
			wait_clk(8);
			chk("osc gated", 16'(osc), 16'(k != 0));
			wr(8'h63, 8'h00);
			wait_clk(3);
			chk("osc on", 16'(osc), 16'h0001);
		end
		wr(8'h63, 8'hF3);
		reg_chk("spare", 8'h63, 8'hF3);
		chk("no ramp", 16'(noramp), 16'h0001);
		chk("od level", 16'(ck_lvl), 16'h0000);
		sel = 1'b1;
		wait_clk(3);
		chk("sel rise", 16'(csel), 16'h0001);
		sel = 1'b0;
		wait_clk(3000);
		chk("sel held", 16'(csel), 16'h0001);
		for (int n = 0; n < 7000 && csel !== 1'b0; n++)
			wait_clk(1);
		chk("sel fall", 16'(csel), 16'h0000);
		wr(8'h63, 8'h04);
		sel = 1'b1;
		wait_clk(3);
		sel = 1'b0;
		wait_clk(3);
		chk("sel fast", 16'(csel), 16'h0000);
		chk("ramp", 16'(noramp), 16'h0000);
		chk("pp enable", 16'(ck_oe), 16'h0001);
		strap_hi = 1'b0;
		strap_lo = 1'b1;
		rst_in = 1'b1;
		wait_clk(2);
		rst_in = 1'b0;
		reg_chk("ls rearm", 8'h62, 8'h04);
		reg_chk("led rearm", 8'h61, 8'h00);
		reg_chk("spare rearm", 8'h63, 8'h00);
		chk("forced on", 16'(sw_on), 16'h0001);
		complete_run();
	end
endmodule

// ===== src/pmlsr_pkg.sv
// Types shared by the misc register bank modules
package pmlsr_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} pmlsr_req_t;

	typedef struct packed {
		logic one;
		logic two;
		logic three;
	} pmlsr_led_t;

	typedef enum logic [1:0] {
		SEL_IDLE,
		SEL_WAIT_RISE,
		SEL_WAIT_FALL
	} pmlsr_sel_state_t;

endpackage

// ===== src/pmlsr_regs.svh
// Register offsets, field positions and reset values of the misc register bank
`ifndef PMLSR_REGS_SVH
`define PMLSR_REGS_SVH

`define PMLSR_OFF_LED 8'h61
`define PMLSR_OFF_LS 8'h62
`define PMLSR_OFF_SPARE 8'h63
`define PMLSR_OFF_VER 8'h64

`define PMLSR_LED_ONE_ON 6
`define PMLSR_LED_TWO_ON 5
`define PMLSR_LED_THREE_ON 4
`define PMLSR_LED_ONE_BLINK 2
`define PMLSR_LED_TWO_BLINK 1
`define PMLSR_LED_THREE_BLINK 0

`define PMLSR_LS_MODE_HI 3
`define PMLSR_LS_MODE_LO 2
`define PMLSR_LS_ILIM_HI 1
`define PMLSR_LS_ILIM_LO 0

`define PMLSR_SP_USER_HI 7
`define PMLSR_SP_USER_LO 4
`define PMLSR_SP_OSC_GATE 3
`define PMLSR_SP_SEL_NODLY 2
`define PMLSR_SP_NO_RAMP 1
`define PMLSR_SP_OPEN_DRAIN 0

`define PMLSR_MODE_OFF 2'h0
`define PMLSR_MODE_FORCED 2'h1
`define PMLSR_MODE_BYP_AUTO 2'h2
`define PMLSR_MODE_BYP_ON 2'h3

`define PMLSR_RST_LED 8'h00
`define PMLSR_RST_ILIM 2'h0
`define PMLSR_RST_SPARE 8'h00
`define PMLSR_RST_RDATA 8'h00

`define PMLSR_MA_STEP 5'h02
`define PMLSR_MA_MAX 5'h14
`define PMLSR_CODE_MAX 4'h9

`define PMLSR_ILIM_MA_0 12'h064
`define PMLSR_ILIM_MA_1 12'h1F4
`define PMLSR_ILIM_MA_2 12'h2EE
`define PMLSR_ILIM_MA_3 12'h9C4

`endif

// ===== src/pmlsr_seldly.sv
// Delays a falling converter selection by 0.5 to 1.5 slow-clock periods
module pmlsr_seldly (
	input wire logic clk_in, // System clock
	input wire logic rst_in, // Synchronous reset, high
	input wire logic sel_in, // Requested selection, same clock
	input wire logic no_delay_in, // Pass falling selection at once
	input wire logic slow_in, // Synchronised 32 kHz clock level
	output logic sel_out // Delayed selection
);

	pmlsr_pkg::pmlsr_sel_state_t state;
	logic slow_q;
	logic slow_rise;
	logic slow_fall;

	assign slow_rise = slow_in && !slow_q;
	assign slow_fall = !slow_in && slow_q;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			slow_q <= 1'b0;
		end else begin
			slow_q <= slow_in;
		end
	end

	// Wait for a rising then a falling slow edge: 0.5 to 1.5 periods
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state <= pmlsr_pkg::SEL_IDLE;
			sel_out <= 1'b0;
		end else begin
			unique case (state)
				pmlsr_pkg::SEL_IDLE: begin
					if (sel_in) begin
						sel_out <= 1'b1;
					end else if (sel_out && no_delay_in) begin
						sel_out <= 1'b0;
					end else if (sel_out) begin
						state <= pmlsr_pkg::SEL_WAIT_RISE;
					end
				end
				pmlsr_pkg::SEL_WAIT_RISE: begin
					if (sel_in || no_delay_in) begin
						state <= pmlsr_pkg::SEL_IDLE;
						sel_out <= sel_in;
					end else if (slow_rise) begin
						state <= pmlsr_pkg::SEL_WAIT_FALL;
					end
				end
				pmlsr_pkg::SEL_WAIT_FALL: begin
					if (sel_in) begin
						state <= pmlsr_pkg::SEL_IDLE;
					end else if (slow_fall || no_delay_in) begin
						state <= pmlsr_pkg::SEL_IDLE;
						sel_out <= 1'b0;
					end
				end
			endcase
		end
	end

	sequence s_delayed_fall;
		!no_delay_in && state == pmlsr_pkg::SEL_WAIT_RISE && !sel_in;
	endsequence

	a_sel_rise_pass: assert property (@(posedge clk_in) disable iff (rst_in)
		sel_in |=> sel_out)
		else $error("raised selection not passed at once");

	a_sel_no_delay: assert property (@(posedge clk_in) disable iff (rst_in)
		(no_delay_in && !sel_in && state == pmlsr_pkg::SEL_IDLE)
		|=> !sel_out)
		else $error("selection delayed although delay is bypassed");

	a_sel_held_delay: assert property (@(posedge clk_in) disable iff (rst_in)
		s_delayed_fall and !slow_rise |=> sel_out)
		else $error("falling selection released before half a period");

endmodule

// ===== src/pmlsr_sync.sv
// Three-stage pin synchroniser; output moves when stages two and three agree
module pmlsr_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in, // System clock
	input wire logic rst_in, // Synchronous reset, high
	input wire logic [WIDTH-1:0] pin_in, // Asynchronous inputs
	output logic [WIDTH-1:0] level_out // Filtered synchronous levels
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	generate
		if (WIDTH < 1) begin : g_bad
			$error("pmlsr_sync: WIDTH must be at least 1");
		end
	endgenerate

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			level_out <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2[i] == stage3[i]) begin
					level_out[i] <= stage3[i];
				end
			end
		end
	end

	a_sync_agree_hold: assert property (@(posedge clk_in) disable iff (rst_in)
		(stage2 != stage3) |=> $stable(level_out) || (level_out == $past(stage3)))
		else $error("synchroniser output moved without agreement");

endmodule

// ===== src/pmlsr_top.sv
// LED enable, load switch, spare and version registers with their outputs
`include "pmlsr_regs.svh"

// Behaviour
// - Bits 6..4 enable the three LED channels
// - Bits 2..0 enable each channel's blink sequencer
// - Reserved bits read zero, ignore writes
// - Current code gives 2 mA steps, max 20
// - Mode 00 off, mode 01 forced on
// - Mode 10 bypass, comparator turns switch on
// - Mode 11 bypass, switch held on
// - Bypass overvoltage blocks PWM, clears mode
// - Mode reset value taken from strap pins
// - Current limit field selects four limits
// - Oscillator gated only when both requests low
// - Falling selection delayed unless bit set
// - Immediate bit bypasses voltage slew ramp
// - Spare bit 0 selects open-drain clock out
// - Version register read-only, OTP and revision
// - All registers return to defaults on reset
module pmlsr_top #(
	parameter logic [3:0] OTP_VERSION = 4'hA, // Arbitrary value
	parameter logic [3:0] SILICON_REV = 4'hA, // Arbitrary value
	parameter logic [1:0] RST_ILIM = `PMLSR_RST_ILIM,
	parameter logic [7:0] RST_SPARE = `PMLSR_RST_SPARE,
	parameter int LED_COUNT = 3
) (
	input wire logic clk_in, // 200 MHz system clock
	input wire logic rst_in, // Power-on reset, synchronous, high
	input pmlsr_pkg::pmlsr_req_t reg_req_in, // Register access request
	input wire logic [11:0] sink_current_code_in, // Three 4-bit codes
	input wire logic switch_mode_strap_hi_in, // Strap for mode bit 1
	input wire logic switch_mode_strap_lo_in, // Strap for mode bit 0
	input wire logic conv_four_output_sense_in, // Overvoltage comparator
	input wire logic bypass_cmp_in, // Converter bypass comparator
	input wire logic power_request_in, // Power request pin
	input wire logic clock_request_in, // Clock request pin
	input wire logic slow_clk_in, // 32 kHz clock pin
	input wire logic conv_select_in, // Requested voltage selection
	output logic [7:0] reg_rdata_out, // Read data, one cycle late
	output pmlsr_pkg::pmlsr_led_t led_on_out, // Channel enables
	output pmlsr_pkg::pmlsr_led_t led_blink_out, // Sequencer enables
	output logic [14:0] led_ma_out, // Three 5-bit currents in mA
	output logic switch_on_out, // Load switch closed
	output logic forced_pwm_block_out, // Block forced PWM
	output logic [1:0] switch_current_limit_out, // Limit code
	output logic [11:0] switch_limit_ma_out, // Limit in mA
	output logic fast_osc_run_out, // Fast oscillator runs
	output logic conv_select_out, // Delayed voltage selection
	output logic conv_voltage_no_ramp_out, // Skip slew ramp
	output logic slow_clock_output_out, // Clock output level
	output logic slow_clock_oe_out // Clock output enable
);

	logic [7:0] led_reg;
	logic [1:0] mode;
	logic [1:0] ilim;
	logic [7:0] spare;
	logic [4:0] pin_raw;
	logic [4:0] pin_sync;
	logic ov_sync;
	logic cmp_sync;
	logic pwr_sync;
	logic clkreq_sync;
	logic slow_sync;
	logic bypass;
	logic hw_clear;
	logic wr_led;
	logic wr_ls;
	logic wr_spare;
	logic [7:0] next_rdata;

	generate
		if (LED_COUNT != 3) begin : g_bad_count
			$error("pmlsr_top: LED_COUNT must be 3");
		end
	endgenerate

	function automatic logic [4:0] code_to_ma(input logic [3:0] code);
		logic [4:0] ma;
		ma = `PMLSR_MA_MAX;
		if (code <= `PMLSR_CODE_MAX) begin
			ma = 5'({1'b0, code} + 5'h01) * `PMLSR_MA_STEP;
		end
		return ma;
	endfunction

	function automatic logic [11:0] ilim_to_ma(input logic [1:0] code);
		logic [11:0] ma;
		ma = `PMLSR_ILIM_MA_0;
		unique case (code)
			2'h0: ma = `PMLSR_ILIM_MA_0;
			2'h1: ma = `PMLSR_ILIM_MA_1;
			2'h2: ma = `PMLSR_ILIM_MA_2;
			2'h3: ma = `PMLSR_ILIM_MA_3;
		endcase
		return ma;
	endfunction

	assign pin_raw = {conv_four_output_sense_in, bypass_cmp_in,
		power_request_in, clock_request_in, slow_clk_in};

	pmlsr_sync #(
		.WIDTH(5)
	) u_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.pin_in(pin_raw),
		.level_out(pin_sync)
	);

	assign ov_sync = pin_sync[4];
	assign cmp_sync = pin_sync[3];
	assign pwr_sync = pin_sync[2];
	assign clkreq_sync = pin_sync[1];
	assign slow_sync = pin_sync[0];

	assign wr_led = reg_req_in.wr && reg_req_in.addr == `PMLSR_OFF_LED;
	assign wr_ls = reg_req_in.wr && reg_req_in.addr == `PMLSR_OFF_LS;
	assign wr_spare = reg_req_in.wr && reg_req_in.addr == `PMLSR_OFF_SPARE;
	assign bypass = mode[1];
	assign hw_clear = bypass && ov_sync;

	// LED enables; reserved bits 7 and 3 never stored
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			led_reg <= `PMLSR_RST_LED;
		end else if (wr_led) begin
			led_reg <= reg_req_in.wdata & 8'h77;
		end
	end

	// Load switch mode; hardware clear wins over a host write
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			mode <= {switch_mode_strap_hi_in, switch_mode_strap_lo_in};
		end else if (hw_clear) begin
			mode <= `PMLSR_MODE_OFF;
		end else if (wr_ls) begin
			mode <= reg_req_in.wdata[`PMLSR_LS_MODE_HI:`PMLSR_LS_MODE_LO];
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ilim <= RST_ILIM;
		end else if (wr_ls) begin
			ilim <= reg_req_in.wdata[`PMLSR_LS_ILIM_HI:`PMLSR_LS_ILIM_LO];
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			spare <= RST_SPARE;
		end else if (wr_spare) begin
			spare <= reg_req_in.wdata;
		end
	end

	// Read port; version is constant and writes to it are dropped
	always_comb begin
		next_rdata = 8'h00;
		unique case (reg_req_in.addr)
			`PMLSR_OFF_LED: next_rdata = led_reg & 8'h77;
			`PMLSR_OFF_LS: next_rdata = {4'h0, mode, ilim};
			`PMLSR_OFF_SPARE: next_rdata = spare;
			`PMLSR_OFF_VER: next_rdata = {OTP_VERSION, SILICON_REV};
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= `PMLSR_RST_RDATA;
		end else if (reg_req_in.rd) begin
			reg_rdata_out <= next_rdata;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			led_on_out <= '0;
			led_blink_out <= '0;
		end else begin
			led_on_out.one <= led_reg[`PMLSR_LED_ONE_ON];
			led_on_out.two <= led_reg[`PMLSR_LED_TWO_ON];
			led_on_out.three <= led_reg[`PMLSR_LED_THREE_ON];
			led_blink_out.one <= led_reg[`PMLSR_LED_ONE_BLINK];
			led_blink_out.two <= led_reg[`PMLSR_LED_TWO_BLINK];
			led_blink_out.three <= led_reg[`PMLSR_LED_THREE_BLINK];
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			led_ma_out <= '0;
		end else begin
			for (int i = 0; i < LED_COUNT; i++) begin
				led_ma_out[i*5 +: 5] <= code_to_ma(sink_current_code_in[i*4 +: 4]);
			end
		end
	end

	// Load switch drive from mode and synchronised comparators
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			switch_on_out <= 1'b0;
			forced_pwm_block_out <= 1'b0;
		end else begin
			unique case (mode)
				`PMLSR_MODE_OFF: switch_on_out <= 1'b0;
				`PMLSR_MODE_FORCED: switch_on_out <= 1'b1;
				`PMLSR_MODE_BYP_AUTO: switch_on_out <= cmp_sync && !ov_sync;
				`PMLSR_MODE_BYP_ON: switch_on_out <= !ov_sync;
			endcase
			forced_pwm_block_out <= hw_clear;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			switch_current_limit_out <= `PMLSR_RST_ILIM;
			switch_limit_ma_out <= `PMLSR_ILIM_MA_0;
		end else begin
			switch_current_limit_out <= ilim;
			switch_limit_ma_out <= ilim_to_ma(ilim);
		end
	end

	// Spare controls: oscillator gating, ramp skip, clock output driver
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			fast_osc_run_out <= 1'b1;
			conv_voltage_no_ramp_out <= 1'b0;
			slow_clock_output_out <= 1'b0;
			slow_clock_oe_out <= 1'b0;
		end else begin
			fast_osc_run_out <= !spare[`PMLSR_SP_OSC_GATE] ||
				pwr_sync || clkreq_sync;
			conv_voltage_no_ramp_out <= spare[`PMLSR_SP_NO_RAMP];
			if (spare[`PMLSR_SP_OPEN_DRAIN]) begin
				slow_clock_output_out <= 1'b0;
				slow_clock_oe_out <= !slow_sync;
			end else begin
				slow_clock_output_out <= slow_sync;
				slow_clock_oe_out <= 1'b1;
			end
		end
	end

	pmlsr_seldly u_seldly (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.sel_in(conv_select_in),
		.no_delay_in(spare[`PMLSR_SP_SEL_NODLY]),
		.slow_in(slow_sync),
		.sel_out(conv_select_out)
	);

	sequence s_bypass_ov;
		bypass && ov_sync;
	endsequence

	a_reserved_led_zero: assert property (@(posedge clk_in) disable iff (rst_in)
		reg_req_in.rd && reg_req_in.addr == `PMLSR_OFF_LED
		|=> reg_rdata_out[7] == 1'b0 && reg_rdata_out[3] == 1'b0)
		else $error("reserved LED bits read nonzero");

	a_led_enable_follow: assert property (@(posedge clk_in)
		disable iff (rst_in)
		wr_led ##1 !wr_led |=> led_on_out.one == $past(led_reg[6]) &&
		led_blink_out.three == $past(led_reg[0]))
		else $error("LED enable output does not follow register");

	a_current_clamp: assert property (@(posedge clk_in) disable iff (rst_in)
		sink_current_code_in[3:0] >= 4'hA |=> led_ma_out[4:0] == 5'h14)
		else $error("high current code not clamped to 20 mA");

	a_mode_off_open: assert property (@(posedge clk_in) disable iff (rst_in)
		mode == `PMLSR_MODE_OFF |=> !switch_on_out)
		else $error("switch closed in off mode");

	a_mode_forced_on: assert property (@(posedge clk_in) disable iff (rst_in)
		mode == `PMLSR_MODE_FORCED |=> switch_on_out)
		else $error("switch open in forced mode");

	a_bypass_auto_cmp: assert property (@(posedge clk_in) disable iff (rst_in)
		mode == `PMLSR_MODE_BYP_AUTO && !ov_sync
		|=> switch_on_out == $past(cmp_sync))
		else $error("auto bypass does not follow comparator");

	a_bypass_held_on: assert property (@(posedge clk_in) disable iff (rst_in)
		mode == `PMLSR_MODE_BYP_ON && !ov_sync |=> switch_on_out)
		else $error("held bypass switch not closed");

	a_ov_clear_mode: assert property (@(posedge clk_in) disable iff (rst_in)
		s_bypass_ov |=> mode == `PMLSR_MODE_OFF && forced_pwm_block_out
		##1 !switch_on_out)
		else $error("overvoltage did not clear bypass mode");

	a_ilim_map: assert property (@(posedge clk_in) disable iff (rst_in)
		ilim == 2'h3 ##1 ilim == 2'h3 |=> switch_limit_ma_out == 12'h9C4)
		else $error("current limit code mapped wrongly");

	a_osc_gate: assert property (@(posedge clk_in) disable iff (rst_in)
		spare[3] && !pwr_sync && !clkreq_sync |=> !fast_osc_run_out)
		else $error("oscillator runs with both requests low");

	a_version_fixed: assert property (@(posedge clk_in) disable iff (rst_in)
		reg_req_in.rd && reg_req_in.addr == `PMLSR_OFF_VER
		|=> reg_rdata_out == {OTP_VERSION, SILICON_REV})
		else $error("version register changed");

	a_reset_defaults: assert property (@(posedge clk_in)
		rst_in |=> led_reg == `PMLSR_RST_LED && ilim == RST_ILIM &&
		spare == RST_SPARE)
		else $error("register not at default after reset");

endmodule
